// [bench/ecg_channel_rate_filter_config_bench.sv]
// Self-checking bench for the ECG channel rate and filter configuration block.
// Assumes the design package is compiled first; drives every port itself.
`timescale 1ns/10ps
`default_nettype none
module ecg_channel_rate_filter_config_bench;
    import ecg_cfg_pkg::*;

    logic clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic [ADDR_W-1:0] addr_i = '0;
    logic [DATA_W-1:0] wdata_i = '0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [1:0] master_clock_select_i = 2'h0;
    logic mclk_tick_i = 1'b0;
    logic resync_command_i = 1'b0;
    logic [DATA_W-1:0] rdata_o;
    logic [1:0] rate_code_o;
    logic rate_reserved_o;
    logic [DIV_W-1:0] sample_divisor_o;
    logic [7:0] gain_vv_o;
    logic highpass_select_o;
    logic [1:0] lowpass_select_o;
    logic lowpass_fir_on_o;
    logic reduced_cutoff_o;
    logic sample_strobe_o;
    logic cfg_changed_o;
    int error_cnt = 0;
    int check_count = 0;
    logic [31:0] seed = 32'h2B71A8AB;
    logic [23:0] rv;
    logic [23:0] w;
    int n;

    ecg_channel_rate_filter_config ecg_channel_rate_filter_config_i (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .master_clock_select_i(master_clock_select_i), .mclk_tick_i(mclk_tick_i),
        .resync_command_i(resync_command_i), .rate_code_o(rate_code_o),
        .rate_reserved_o(rate_reserved_o), .sample_divisor_o(sample_divisor_o),
        .gain_vv_o(gain_vv_o), .highpass_select_o(highpass_select_o),
        .lowpass_select_o(lowpass_select_o), .lowpass_fir_on_o(lowpass_fir_on_o),
        .reduced_cutoff_o(reduced_cutoff_o), .sample_strobe_o(sample_strobe_o),
        .cfg_changed_o(cfg_changed_o)
    );

    initial
    begin
        forever #10 clk_i = ~clk_i;
    end

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // Effective low-pass code for a clock, rate and written code
    function automatic logic [1:0] eff_lpf(input logic [1:0] m, input logic [1:0] r,
                                           input logic [1:0] l);
        if (l == 2'h0) return 2'h0;
        if (m[1] || r[1] || (r == 2'h1 && l == 2'h3)) return 2'h1;
        return l;
    endfunction

    function automatic logic rsvd(input logic [1:0] m, input logic [1:0] r);
        return m[1] ? (r != 2'h2) : (r == 2'h3);
    endfunction

    function automatic logic [8:0] exp_div(input logic [1:0] m, input logic [1:0] r);
        if (m[1]) return 9'h0A0;
        return 9'h040 << r;
    endfunction

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        check_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [23:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [23:0] d);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        d = rdata_o;
    endtask

    task automatic pulse_resync();
        @(posedge clk_i);
        resync_command_i <= 1'b1;
        @(posedge clk_i);
        resync_command_i <= 1'b0;
    endtask

    task automatic end_sim();
        $display("Checks %0d, errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial
    begin
        #(20 * 30000);
        error_cnt++;
        $display("Error at %0t: watchdog expired", $time);
        end_sim();
    end

    initial
    begin
        repeat (10) @(posedge clk_i);
        arst_n_i <= 1'b1;
        #1;
        chk(gain_vv_o, 24'd20);
        chk(sample_divisor_o, 24'h100);
        chk({rate_reserved_o, cfg_changed_o}, 24'h0);
        rd(ECG_CFG_ADDR, rv);
        chk(rv, 24'h805000);
        // Unmapped write must not touch the register
        wr(8'h14, 24'hFFFFFF);
        rd(8'h14, rv);
        chk(rv, 24'h0);
        rd(ECG_CFG_ADDR, rv);
        chk(rv, 24'h805000);
        // Every clock, rate and low-pass pairing with random other bits
        for (int i = 0; i < 64; i++)
        begin
            seed = xorshift(seed);
            w = {i[3:2], seed[21:14], i[1:0], seed[11:0]};
            @(posedge clk_i);
            master_clock_select_i <= i[5:4];
            wr(ECG_CFG_ADDR, w);
            repeat (3) @(posedge clk_i);
            #1;
            chk(rate_code_o, w[23:22]);
            chk(rate_reserved_o, rsvd(i[5:4], i[3:2]));
            if (!rsvd(i[5:4], i[3:2]))
                chk(sample_divisor_o, exp_div(i[5:4], i[3:2]));
            chk(gain_vv_o, 24'd20 << w[17:16]);
            chk(highpass_select_o, w[14]);
            chk(lowpass_select_o, eff_lpf(i[5:4], i[3:2], i[1:0]));
            chk(lowpass_fir_on_o, i[1:0] != 2'h0);
            chk(reduced_cutoff_o, !i[5] && i[3:2] == 2'h2 && i[1:0] != 2'h0);
            rd(ECG_CFG_ADDR, rv);
            chk(rv, {w[23:22], 4'h0, w[17:16], 1'b0, w[14],
                     eff_lpf(i[5:4], i[3:2], i[1:0]), 12'h0});
        end
        // Change flag: set on change, cleared by resync, kept clear by same value
        @(posedge clk_i);
        master_clock_select_i <= 2'h0;
        pulse_resync();
        wr(ECG_CFG_ADDR, 24'h001000);
        #1;
        chk(cfg_changed_o, 1'b1);
        pulse_resync();
        wr(ECG_CFG_ADDR, 24'h001000);
        #1;
        chk(cfg_changed_o, 1'b0);
        // Write and resync in one cycle: the change wins
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= ECG_CFG_ADDR;
        wdata_i <= 24'h002000;
        resync_command_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
        resync_command_i <= 1'b0;
        #1;
        chk(cfg_changed_o, 1'b1);
        // Sample spacing after resync for three clock and rate settings
        @(posedge clk_i);
        mclk_tick_i <= 1'b1;
        for (int k = 0; k < 3; k++)
        begin
            @(posedge clk_i);
            master_clock_select_i <= (k == 1) ? 2'h2 : 2'h0;
            wr(ECG_CFG_ADDR, (k == 0) ? 24'h001000 : (k == 1) ? 24'h801000 : 24'hC01000);
            pulse_resync();
            #1;
            n = 0;
            while (sample_strobe_o !== 1'b1 && n < 400)
            begin
                @(posedge clk_i);
                #1;
                n++;
            end
            if (k == 2)
                chk(n, 24'd400);
            else
            begin
                chk(n, (k == 0) ? 24'd64 : 24'd160);
                n = 0;
                @(posedge clk_i);
                #1;
                while (sample_strobe_o !== 1'b1 && n < 400)
                begin
                    @(posedge clk_i);
                    #1;
                    n++;
                end
                chk(n + 1, (k == 0) ? 24'd64 : 24'd160);
            end
        end
        end_sim();
    end
endmodule // ecg_channel_rate_filter_config_bench
`default_nettype wire

// [hw/ecg_cfg_pkg.sv]
// Constants for the ECG channel rate and filter configuration block.
// Assumes one 50 MHz clock and a plain register port.
package ecg_cfg_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 24;
    localparam logic [ADDR_W-1:0] ECG_CFG_ADDR = 8'h15;

    // Field positions
    localparam int RATE_LSB = 22;
    localparam int GAIN_LSB = 16;
    localparam int HPF_BIT = 14;
    localparam int LPF_LSB = 12;

    // Reset values
    localparam logic [1:0] RATE_RST = 2'h2;
    localparam logic [1:0] GAIN_RST = 2'h0;
    localparam logic HPF_RST = 1'b1;
    localparam logic [1:0] LPF_RST = 2'h1;

    // Rate, low-pass and master-clock codes
    localparam logic [1:0] RATE_FULL = 2'h0;
    localparam logic [1:0] RATE_HALF = 2'h1;
    localparam logic [1:0] RATE_QUARTER = 2'h2;
    localparam logic [1:0] RATE_RSVD = 2'h3;
    localparam logic [1:0] LPF_BYPASS = 2'h0;
    localparam logic [1:0] LPF_40HZ = 2'h1;
    localparam logic [1:0] LPF_100HZ = 2'h2;
    localparam logic [1:0] LPF_150HZ = 2'h3;
    localparam logic [1:0] MCLK_32768 = 2'h0;
    localparam logic [1:0] MCLK_32000 = 2'h1;

    // Master-clock ticks per output sample
    localparam int DIV_W = 9;
    localparam logic [DIV_W-1:0] DIV_FULL = 9'h040;
    localparam logic [DIV_W-1:0] DIV_HALF = 9'h080;
    localparam logic [DIV_W-1:0] DIV_QUARTER = 9'h100;
    localparam logic [DIV_W-1:0] DIV_200 = 9'h0A0;

    // Channel gain in V/V
    localparam logic [7:0] GAIN_20 = 8'h14;
    localparam logic [7:0] GAIN_40 = 8'h28;
    localparam logic [7:0] GAIN_80 = 8'h50;
    localparam logic [7:0] GAIN_160 = 8'hA0;

endpackage

// [hw/ecg_channel_rate_filter_config.sv]
// ECG channel configuration register, effective filter mapping and sample timing.
// Assumes a plain register port and a master-clock tick enable from outside.
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module ecg_channel_rate_filter_config
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // Register port
    input wire logic [ecg_cfg_pkg::ADDR_W-1:0] addr_i,
    input wire logic [ecg_cfg_pkg::DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [ecg_cfg_pkg::DATA_W-1:0] rdata_o,
    // Master clock selection and timing
    input wire logic [1:0] master_clock_select_i,
    input wire logic mclk_tick_i,
    input wire logic resync_command_i,
    // Effective channel settings
    output logic [1:0] rate_code_o,
    output logic rate_reserved_o,
    output logic [ecg_cfg_pkg::DIV_W-1:0] sample_divisor_o,
    output logic [7:0] gain_vv_o,
    output logic highpass_select_o,
    output logic [1:0] lowpass_select_o,
    output logic lowpass_fir_on_o,
    output logic reduced_cutoff_o,
    // Sample timing
    output logic sample_strobe_o,
    output logic cfg_changed_o
);
    import ecg_cfg_pkg::*;

    logic [1:0] rate_q;
    logic [1:0] gain_q;
    logic hpf_q;
    logic [1:0] lpf_q;
    logic [1:0] lpf_eff;
    logic [DIV_W-1:0] div_d;
    logic rate_bad;
    logic slow_rate;
    logic [7:0] gain_d;
    logic cfg_wr;
    logic [DATA_W-1:0] cfg_word;
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;
    logic changed_q;
    logic [7:0] gain_vv_q;
    logic [DIV_W-1:0] div_q;
    logic [1:0] lpf_eff_q;
    logic bad_q;
    localparam logic [DATA_W-1:0] CFG_MASK = 24'hC37000;
    logic [DATA_W-1:0] cfg_store_word;

    assign cfg_wr = wr_i && (addr_i == ECG_CFG_ADDR);

    // Stored fields; other bits are not kept
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            rate_q <= RATE_RST;
            gain_q <= GAIN_RST;
            hpf_q <= HPF_RST;
            lpf_q <= LPF_RST;
        end
        else if (cfg_wr)
        begin
            rate_q <= wdata_i[RATE_LSB +: 2];
            gain_q <= wdata_i[GAIN_LSB +: 2];
            hpf_q <= wdata_i[HPF_BIT];
            lpf_q <= wdata_i[LPF_LSB +: 2]; // written value kept
        end
    end

    // Rate validity and ticks per sample for the active master clock
    always_comb
    begin
        rate_bad = 1'b0;
        slow_rate = 1'b0;
        div_d = DIV_QUARTER;
        if (master_clock_select_i == MCLK_32768 || master_clock_select_i == MCLK_32000)
        begin
            unique case (rate_q)
                RATE_FULL: div_d = DIV_FULL;
                RATE_HALF: div_d = DIV_HALF;
                RATE_QUARTER:
                begin
                    div_d = DIV_QUARTER;
                    slow_rate = 1'b1;
                end
                RATE_RSVD: rate_bad = 1'b1;
            endcase
        end
        else
        begin
            div_d = DIV_200;
            rate_bad = (rate_q != RATE_QUARTER);
        end
    end

    // Effective low-pass code
    always_comb
    begin
        lpf_eff = lpf_q;
        if (lpf_q == LPF_BYPASS)
        begin
            lpf_eff = LPF_BYPASS;
        end
        else if (master_clock_select_i == MCLK_32768 || master_clock_select_i == MCLK_32000)
        begin
            if (rate_q == RATE_HALF && lpf_q == LPF_150HZ)
            begin
                lpf_eff = LPF_40HZ;
            end
            else if (rate_q == RATE_QUARTER || rate_q == RATE_RSVD)
            begin
                lpf_eff = LPF_40HZ;
            end
        end
        else
        begin
            lpf_eff = LPF_40HZ;
        end
    end

    // Gain in V/V
    always_comb
    begin
        unique case (gain_q)
            2'h0: gain_d = GAIN_20;
            2'h1: gain_d = GAIN_40;
            2'h2: gain_d = GAIN_80;
            2'h3: gain_d = GAIN_160;
        endcase
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            gain_vv_q <= GAIN_20;
            div_q <= DIV_QUARTER;
            lpf_eff_q <= LPF_RST;
            bad_q <= 1'b0;
        end
        else
        begin
            gain_vv_q <= gain_d;
            div_q <= div_d;
            lpf_eff_q <= lpf_eff;
            bad_q <= rate_bad;
        end
    end

    assign gain_vv_o = gain_vv_q;
    assign sample_divisor_o = div_q;
    assign lowpass_select_o = lpf_eff_q;
    assign rate_reserved_o = bad_q; // flags a rate code not valid for the master clock, one cycle late
    assign rate_code_o = rate_q;
    assign highpass_select_o = hpf_q;
    assign lowpass_fir_on_o = (lpf_eff_q != LPF_BYPASS);
    assign reduced_cutoff_o = slow_rate && (lpf_q != LPF_BYPASS);

    // Readback with effective low-pass, unassigned bits zero
    always_comb
    begin
        cfg_word = '0;
        cfg_word[RATE_LSB +: 2] = rate_q;
        cfg_word[GAIN_LSB +: 2] = gain_q;
        cfg_word[HPF_BIT] = hpf_q;
        cfg_word[LPF_LSB +: 2] = lpf_eff;
        rdata_d = (addr_i == ECG_CFG_ADDR) ? cfg_word : '0;
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            rdata_q <= '0;
        end
        else if (rd_i)
        begin
            rdata_q <= rdata_d;
        end
        else
        begin
            rdata_q <= '0;
        end
    end

    assign rdata_o = rdata_q;

    // Sticky change flag, resync clears, a new change wins
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            changed_q <= 1'b0;
        end
        else if (cfg_wr && (wdata_i & CFG_MASK) != (cfg_store_word & CFG_MASK))
        begin
            changed_q <= 1'b1;
        end
        else if (resync_command_i)
        begin
            changed_q <= 1'b0;
        end
    end

    assign cfg_store_word = {rate_q, 4'h0, gain_q, 1'b0, hpf_q, lpf_q, 12'h000};
    assign cfg_changed_o = changed_q;

    ecg_sample_strobe #(
        .DIV_W(DIV_W)
    ) ecg_sample_strobe_i (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .mclk_tick_i(mclk_tick_i),
        .run_i(!rate_bad),
        .realign_i(resync_command_i),
        .divisor_i(div_d),
        .strobe_o(sample_strobe_o),
        .phase_o()
    );

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!arst_n_i);

    AST_READ_EFFECTIVE_LPF:
    assert property (rd_i && addr_i == ECG_CFG_ADDR |=> rdata_o[13:12] == $past(lpf_eff))
        else $error("readback low-pass is not the effective code");
    AST_BYPASS_KEEPS_BYPASS:
    assert property (lpf_q == LPF_BYPASS |=> lowpass_select_o == LPF_BYPASS)
        else $error("bypass code was remapped");
    AST_SLOW_RATE_DEFAULT:
    assert property (master_clock_select_i[1] == 1'b0 && rate_q == RATE_QUARTER
        && lpf_q != LPF_BYPASS |=> lowpass_select_o == LPF_40HZ)
        else $error("slow rate low-pass not mapped to default");
    AST_HALF_RATE_150:
    assert property (master_clock_select_i[1] == 1'b0 && rate_q == RATE_HALF
        && lpf_q == LPF_150HZ |=> lowpass_select_o == LPF_40HZ)
        else $error("150 Hz allowed at half rate");
    AST_FULL_RATE_KEEPS:
    assert property (master_clock_select_i[1] == 1'b0 && rate_q == RATE_FULL
        |=> lowpass_select_o == $past(lpf_q))
        else $error("full rate low-pass changed");
    AST_GAIN_MAP:
    assert property (gain_q == 2'h3 ##1 gain_q == 2'h3 |-> gain_vv_o == GAIN_160)
        else $error("gain 11 not 160 V/V");
    AST_DIV_FULL:
    assert property (master_clock_select_i[1] == 1'b0 && rate_q == RATE_FULL
        |=> sample_divisor_o == DIV_FULL)
        else $error("full rate divisor wrong");
    AST_DIV_200:
    assert property (master_clock_select_i[1] && rate_q == RATE_QUARTER
        |=> sample_divisor_o == DIV_200 && !rate_reserved_o)
        else $error("200 sps divisor wrong");
    AST_RESERVED_RATE:
    assert property (master_clock_select_i == MCLK_32000 && rate_q == RATE_RSVD
        |=> rate_reserved_o)
        else $error("reserved rate not flagged");
    AST_UNUSED_ZERO:
    assert property (rd_i |=> (rdata_o & ~CFG_MASK) == '0)
        else $error("unassigned bits read nonzero");
    AST_HPF_FOLLOWS:
    assert property (cfg_wr |=> highpass_select_o == $past(wdata_i[HPF_BIT]))
        else $error("high-pass bit not taken");
    AST_CHANGE_SETS:
    assert property (cfg_wr && (wdata_i & CFG_MASK) != (cfg_store_word & CFG_MASK)
        |=> cfg_changed_o)
        else $error("config change not flagged");
    AST_RESYNC_CLEARS:
    assert property (resync_command_i && !cfg_wr |=> !cfg_changed_o)
        else $error("resync did not clear change flag");
    AST_RESERVED_NO_STROBE:
    assert property (rate_bad |=> !sample_strobe_o)
        else $error("sample strobe at reserved rate");
    AST_RATE_TAKEN:
    assert property (cfg_wr |=> rate_code_o == $past(wdata_i[RATE_LSB +: 2]))
        else $error("rate field not taken");
    AST_LPF_WRITTEN_KEPT:
    assert property (cfg_wr |=> lpf_q == $past(wdata_i[LPF_LSB +: 2]))
        else $error("written low-pass code not kept");
endmodule // ecg_channel_rate_filter_config
`default_nettype wire

// [hw/ecg_sample_strobe.sv]
// Sample-instant divider: counts master-clock ticks, one strobe per sample.
// Assumes mclk_tick_i is a one-cycle enable at the master-clock rate.
`timescale 1ns/10ps
`default_nettype none
module ecg_sample_strobe
#(
    parameter int DIV_W = 9
)
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // Control
    input wire logic mclk_tick_i,
    input wire logic run_i,
    input wire logic realign_i,
    input wire logic [DIV_W-1:0] divisor_i,
    // Result
    output logic strobe_o,
    output logic [DIV_W-1:0] phase_o
);
    logic [DIV_W-1:0] cnt_q;
    logic strobe_q;
    logic wrap;

    assign wrap = (cnt_q >= divisor_i - DIV_W'(1));

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            cnt_q <= '0;
        end
        else if (realign_i || !run_i)
        begin
            cnt_q <= '0;
        end
        else if (mclk_tick_i)
        begin
            cnt_q <= wrap ? '0 : cnt_q + DIV_W'(1);
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            strobe_q <= 1'b0;
        end
        else
        begin
            strobe_q <= run_i && !realign_i && mclk_tick_i && wrap;
        end
    end

    assign strobe_o = strobe_q;
    assign phase_o = cnt_q;
endmodule // ecg_sample_strobe
`default_nettype wire
